/* File: verilog/asr_receiver.sv */
`timescale 1ns/1ps
module asr_receiver
	import asr_pkg::*;
#(
	parameter int BAUD_W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serialInPin,
	input wire logic cpuWaitMode,
	output logic rxIrq,
	output logic errIrq,
	output logic waitWake
);
	function automatic logic maj3(input logic [2:0] s);
		return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction
	function automatic logic odd3(input logic [2:0] s);
		return (s != 3'b000) && (s != 3'b111);
	endfunction

	logic [5:0] ctrlOne_q;
	logic [3:0] ctrlTwo_q;
	logic [4:0] ctrlThreeEn_q;
	logic [BAUD_W-1:0] baud_q;
	asr_flags_s flags_q;
	logic breakSeen_q;
	logic [7:0] dataBuf_q;
	logic ninth_q;
	logic statusArmed_q;
	logic pinMeta_q, pinSync_q;
	logic [BAUD_W-1:0] baudCnt_q;
	logic tick;
	asr_state_e state_q;
	logic [3:0] rt_q;
	logic [2:0] hist_q;
	logic [2:0] samp_q;
	logic [3:0] bitIdx_q;
	logic [8:0] shift_q;
	logic prevBit_q;
	logic lastPin_q;
	logic [8:0] rxData;
	logic addrMark;
	logic frameNoise_q;
	logic [3:0] onesCnt_q;
	logic idleArmed_q;
	logic idleCounting_q;
	logic busRd, busWr, statusRead, dataRead;
	logic nineBit, rxOn;
	logic sampNow, bitDone, bitVal, bitNoise;
	logic charDone, parityBad, isBreak, idleHit;

	assign nineBit = ctrlOne_q[C1_NINE];
	assign rxOn = ctrlOne_q[C1_ENABLE] & ctrlTwo_q[C2_RX_EN];
	assign busRd = psel & penable & ~pwrite;
	assign busWr = psel & penable & pwrite;
	// reads while the cpu waits neither arm nor complete flag clearing
	assign statusRead = busRd & ~cpuWaitMode & (paddr == ADDR_STATUS_ONE);
	assign dataRead = busRd & ~cpuWaitMode & (paddr == ADDR_DATA);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pinMeta_q <= 1'b1;
			pinSync_q <= 1'b1;
		end else begin
			pinMeta_q <= serialInPin;
			pinSync_q <= pinMeta_q;
		end
	end

	// tick every baud_q+1 clocks, sixteen per bit time
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			baudCnt_q <= '0;
		end else if (!rxOn || baudCnt_q == baud_q) begin
			baudCnt_q <= '0;
		end else begin
			baudCnt_q <= baudCnt_q + 1'b1;
		end
	end
	assign tick = rxOn && (baudCnt_q == baud_q);

	assign sampNow = tick && (rt_q == TICK_SAMP_C);
	assign bitVal = maj3({samp_q[1:0], pinSync_q});
	assign bitNoise = odd3({samp_q[1:0], pinSync_q});
	assign bitDone = tick && (rt_q == TICK_LAST);

	// character completes at stop bit sample
	assign charDone = sampNow && (state_q == ASR_STOP);
	// 8-bit characters still sit one place up at the stop sample
	assign rxData = nineBit ? shift_q : {1'b0, shift_q[8:1]};
	assign addrMark = nineBit ? rxData[8] : rxData[7];
	assign isBreak = charDone && !bitVal && (rxData == 9'h000) && !prevBit_q;
	always_comb begin
		logic p;
		p = ^rxData;
		// parity bit sits in top position, included in the xor
		parityBad = ctrlOne_q[C1_PARITY_ON] &&
			(p != ctrlOne_q[C1_PARITY_ODD]);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ASR_HUNT;
			rt_q <= 4'h0;
			hist_q <= 3'b000;
			samp_q <= 3'b000;
			bitIdx_q <= 4'h0;
			shift_q <= 9'h000;
			prevBit_q <= 1'b1;
			lastPin_q <= 1'b1;
			frameNoise_q <= 1'b0;
		end else if (!rxOn) begin
			state_q <= ASR_HUNT;
			rt_q <= 4'h0;
			hist_q <= 3'b000;
		end else if (tick) begin
			rt_q <= rt_q + 4'h1;
			lastPin_q <= pinSync_q;
			if (rt_q == TICK_SAMP_A || rt_q == TICK_SAMP_B ||
				rt_q == TICK_START_A || rt_q == TICK_START_B) begin
				samp_q <= {samp_q[1:0], pinSync_q};
			end
			case (state_q)
				ASR_HUNT: begin
					hist_q <= {hist_q[1:0], pinSync_q};
					rt_q <= 4'h0;
					if (hist_q == 3'b111 && !pinSync_q) begin
						state_q <= ASR_START;
						rt_q <= 4'h2;
						frameNoise_q <= 1'b0;
					end
				end
				ASR_START: begin
					if (rt_q == TICK_START_C) begin
						// 2+ zeros of the three verify
						if (maj3({samp_q[1:0], pinSync_q})) begin
							state_q <= ASR_HUNT;
							hist_q <= 3'b000;
							rt_q <= 4'h0;
						end else if (odd3({samp_q[1:0], pinSync_q})) begin
							frameNoise_q <= 1'b1;
						end
					end
					if (rt_q == TICK_SAMP_C) begin
						if ({samp_q[1:0], pinSync_q} != 3'b000) begin
							frameNoise_q <= 1'b1;
						end
					end
					if (rt_q == TICK_LAST) begin
						state_q <= ASR_DATA;
						bitIdx_q <= 4'h0;
						prevBit_q <= 1'b0;
					end
				end
				ASR_DATA: begin
					if (rt_q == TICK_SAMP_C) begin
						shift_q <= {bitVal, shift_q[8:1]};
						prevBit_q <= bitVal;
						if (bitNoise) begin
							frameNoise_q <= 1'b1;
						end
					end
					// 1-to-0 edge just after a boundary restarts the bit;
					// only early ticks, so the bit end is never skipped
					if (prevBit_q && lastPin_q && !pinSync_q &&
						rt_q < TICK_START_A) begin
						rt_q <= 4'h2;
					end
					if (bitDone) begin
						bitIdx_q <= bitIdx_q + 4'h1;
						if (bitIdx_q == (nineBit ? 4'h8 : 4'h7)) begin
							state_q <= ASR_STOP;
						end
					end
				end
				ASR_STOP: begin
					if (rt_q == TICK_SAMP_C) begin
						state_q <= ASR_HUNT;
						hist_q <= 3'b000;
					end
				end
				default: state_q <= ASR_HUNT;
			endcase
		end
	end

	// bit timer for the idle line; the frame tick counter rests in hunt
	logic [3:0] idleDiv_q;
	logic idleBitDone;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			idleDiv_q <= 4'h0;
		end else if (state_q != ASR_HUNT || !rxOn) begin
			idleDiv_q <= 4'h0;
		end else if (tick) begin
			idleDiv_q <= idleDiv_q + 4'h1;
		end
	end
	assign idleBitDone = tick && state_q == ASR_HUNT && idleDiv_q == TICK_LAST;

	// ones counting for idle detection
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			onesCnt_q <= 4'h0;
			idleArmed_q <= 1'b0;
			idleCounting_q <= 1'b0;
		end else begin
			if (sampNow) begin
				if (state_q == ASR_START) begin
					idleArmed_q <= 1'b1;
					idleCounting_q <= ~ctrlOne_q[C1_IDLE_SEL];
					onesCnt_q <= 4'h0;
				end else if (state_q == ASR_STOP) begin
					idleCounting_q <= 1'b1;
					if (ctrlOne_q[C1_IDLE_SEL] || !bitVal) begin
						onesCnt_q <= 4'h0;
					end else if (!idleHit) begin
						onesCnt_q <= onesCnt_q + 4'h1;
					end
				end else if (!idleCounting_q || !bitVal) begin
					onesCnt_q <= 4'h0;
				end else if (!idleHit) begin
					onesCnt_q <= onesCnt_q + 4'h1;
				end
			end else if (idleBitDone) begin
				if (!pinSync_q) begin
					onesCnt_q <= 4'h0;
				end else if (idleCounting_q && !idleHit) begin
					onesCnt_q <= onesCnt_q + 4'h1;
				end
			end
			// disarm at once so each idle stretch makes one event
			if (idleHit) begin
				idleArmed_q <= 1'b0;
			end
		end
	end
	// armed only at a frame's start bit sample, so one idle line flags once
	assign idleHit = idleCounting_q && idleArmed_q &&
		(onesCnt_q >= (nineBit ? IDLE_BITS_NINE : IDLE_BITS_EIGHT));

	logic idleEvent;
	// idleHit lasts one cycle, disarmed on the same edge
	assign idleEvent = idleHit;

	// status read arms clearing; data read completes it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			statusArmed_q <= 1'b0;
		end else if (dataRead) begin
			statusArmed_q <= 1'b0;
		end else if (statusRead && flags_q != '0) begin
			statusArmed_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_q <= '0;
			breakSeen_q <= 1'b0;
			dataBuf_q <= 8'h00;
			ninth_q <= 1'b0;
		end else begin
			if (dataRead && statusArmed_q) begin
				flags_q <= '0;
				breakSeen_q <= 1'b0;
			end
			if (idleEvent && !(ctrlTwo_q[C2_STANDBY] &&
				!ctrlOne_q[C1_WAKE_ADDR])) begin
				flags_q.idle <= 1'b1;
			end
			// set wins over a same-cycle clear
			if (charDone && !(ctrlTwo_q[C2_STANDBY] &&
				!(ctrlOne_q[C1_WAKE_ADDR] && addrMark))) begin
				if (flags_q.full && !(dataRead && statusArmed_q)) begin
					flags_q.overrun <= 1'b1;
				end else begin
					dataBuf_q <= isBreak ? 8'h00 : rxData[7:0];
					ninth_q <= isBreak ? 1'b0 : addrMark;
					flags_q.full <= 1'b1;
				end
				flags_q.framingErr <= !bitVal;
				if (bitNoise || frameNoise_q) begin
					flags_q.noise <= 1'b1;
				end
				if (parityBad) begin
					flags_q.parityErr <= 1'b1;
				end
				if (isBreak) begin
					breakSeen_q <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrlOne_q <= '0;
			ctrlTwo_q <= '0;
			ctrlThreeEn_q <= '0;
			baud_q <= BAUD_RESET[BAUD_W-1:0];
		end else begin
			if (busWr && !cpuWaitMode) begin
				case (paddr)
					ADDR_CTRL_ONE: ctrlOne_q <= pwdata[5:0];
					ADDR_CTRL_TWO: ctrlTwo_q <= pwdata[3:0];
					ADDR_CTRL_THREE: ctrlThreeEn_q <= {1'b0, pwdata[4:1]};
					ADDR_BAUD: baud_q <= pwdata[BAUD_W-1:0];
					default: ;
				endcase
			end
			// wakeup clears standby, overriding a write
			if (ctrlTwo_q[C2_STANDBY]) begin
				if (charDone && ctrlOne_q[C1_WAKE_ADDR] && addrMark) begin
					ctrlTwo_q[C2_STANDBY] <= 1'b0;
				end
				if (!ctrlOne_q[C1_WAKE_ADDR] && idleHit) begin
					ctrlTwo_q[C2_STANDBY] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rxIrq <= 1'b0;
			errIrq <= 1'b0;
			waitWake <= 1'b0;
		end else begin
			rxIrq <= !ctrlTwo_q[C2_STANDBY] &&
				((flags_q.full && ctrlTwo_q[C2_RX_FULL_IE]) ||
				(flags_q.idle && ctrlTwo_q[C2_IDLE_IE]));
			errIrq <= !ctrlTwo_q[C2_STANDBY] &&
				((flags_q.overrun && ctrlThreeEn_q[C3_OVERRUN_IE - 1]) ||
				(flags_q.noise && ctrlThreeEn_q[C3_NOISE_IE - 1]) ||
				(flags_q.framingErr && ctrlThreeEn_q[C3_FRAMING_IE - 1]) ||
				(flags_q.parityErr && ctrlThreeEn_q[C3_PARITY_IE - 1]));
			waitWake <= cpuWaitMode && (rxIrq || errIrq);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					ADDR_CTRL_ONE: prdata <= {26'h0, ctrlOne_q};
					ADDR_CTRL_TWO: prdata <= {28'h0, ctrlTwo_q};
					ADDR_CTRL_THREE: prdata <= {26'h0, ctrlThreeEn_q, ninth_q};
					ADDR_STATUS_ONE: prdata <= {26'h0, flags_q};
					ADDR_STATUS_TWO: prdata <= {30'h0, breakSeen_q,
						state_q != ASR_HUNT};
					ADDR_DATA: prdata <= {24'h0, dataBuf_q};
					ADDR_BAUD: prdata <= {{(32 - BAUD_W){1'b0}}, baud_q};
					default: pslverr <= 1'b1;
				endcase
			end else if (psel && !penable) begin
				case (paddr)
					ADDR_CTRL_ONE, ADDR_CTRL_TWO, ADDR_CTRL_THREE,
					ADDR_BAUD: pslverr <= 1'b0;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	a_start_noise: assert property (@(posedge clk) disable iff (!arst_n)
		charDone && frameNoise_q |=> flags_q.noise)
		else $error("noise lost at character end");
	a_frame_with_full: assert property (@(posedge clk) disable iff (!arst_n)
		charDone && !bitVal && !ctrlTwo_q[C2_STANDBY] |=> flags_q.framingErr)
		else $error("framing error not set");
	a_overrun_keeps: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(flags_q.overrun) |-> $stable(dataBuf_q))
		else $error("overrun changed buffer");
	a_standby_quiet: assert property (@(posedge clk) disable iff (!arst_n)
		ctrlTwo_q[C2_STANDBY] && $past(ctrlTwo_q[C2_STANDBY]) |=> !rxIrq)
		else $error("irq during standby");
	a_break_clears: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(breakSeen_q) |-> dataBuf_q == 8'h00 && !ninth_q)
		else $error("break did not clear buffer");
	a_start_fail: assert property (@(posedge clk) disable iff (!arst_n)
		tick && state_q == ASR_START && rt_q == TICK_START_C &&
		maj3({samp_q[1:0], pinSync_q}) |=> state_q == ASR_HUNT)
		else $error("failed start not abandoned");
	a_tick_rate: assert property (@(posedge clk) disable iff (!arst_n)
		tick && state_q == ASR_DATA && rt_q == 4'h3 |=> rt_q == 4'h4)
		else $error("tick counter skipped");
	a_full_clear: assert property (@(posedge clk) disable iff (!arst_n)
		dataRead && statusArmed_q && !charDone && !idleEvent |=> !flags_q.full)
		else $error("full not cleared");
endmodule

/* File: verilog/asr_pkg.sv */
package asr_pkg;
	localparam logic [11:0] ADDR_CTRL_ONE = 12'h000;
	localparam logic [11:0] ADDR_CTRL_TWO = 12'h004;
	localparam logic [11:0] ADDR_CTRL_THREE = 12'h008;
	localparam logic [11:0] ADDR_STATUS_ONE = 12'h00C;
	localparam logic [11:0] ADDR_STATUS_TWO = 12'h010;
	localparam logic [11:0] ADDR_DATA = 12'h014;
	localparam logic [11:0] ADDR_BAUD = 12'h018;
	// serial_ctrl_one fields
	localparam int C1_NINE = 0;
	localparam int C1_WAKE_ADDR = 1;
	localparam int C1_IDLE_SEL = 2;
	localparam int C1_PARITY_ON = 3;
	localparam int C1_PARITY_ODD = 4;
	localparam int C1_ENABLE = 5;
	// serial_ctrl_two fields
	localparam int C2_RX_FULL_IE = 0;
	localparam int C2_IDLE_IE = 1;
	localparam int C2_STANDBY = 2;
	localparam int C2_RX_EN = 3;
	// serial_ctrl_three fields
	localparam int C3_NINTH = 0;
	localparam int C3_PARITY_IE = 1;
	localparam int C3_FRAMING_IE = 2;
	localparam int C3_NOISE_IE = 3;
	localparam int C3_OVERRUN_IE = 4;
	// serial_status_one fields
	localparam int S1_PARITY = 0;
	localparam int S1_FRAMING = 1;
	localparam int S1_NOISE = 2;
	localparam int S1_OVERRUN = 3;
	localparam int S1_IDLE = 4;
	localparam int S1_FULL = 5;
	// serial_status_two fields
	localparam int S2_IN_PROGRESS = 0;
	localparam int S2_BREAK = 1;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_START_A = 4'h3;
	localparam logic [3:0] TICK_START_B = 4'h5;
	localparam logic [3:0] TICK_START_C = 4'h7;
	localparam logic [3:0] TICK_SAMP_A = 4'h8;
	localparam logic [3:0] TICK_SAMP_B = 4'h9;
	localparam logic [3:0] TICK_SAMP_C = 4'hA;
	localparam logic [3:0] IDLE_BITS_EIGHT = 4'hA;
	localparam logic [3:0] IDLE_BITS_NINE = 4'hB;
	typedef enum logic [1:0] {ASR_HUNT, ASR_START, ASR_DATA, ASR_STOP} asr_state_e;
	// member order follows the status field positions, full on top
	typedef struct packed {
		logic full;
		logic idle;
		logic overrun;
		logic noise;
		logic framingErr;
		logic parityErr;
	} asr_flags_s;
endpackage

/* File: test/asr_remote_tx.sv */
`timescale 1ns/1ps
module asr_remote_tx #(
	parameter int BIT_CLKS = 32
) (
	input wire logic clk,
	output logic serialOut
);
	initial begin
		serialOut = 1'h1;
	end
	// lsb first; a one-tick flip near mid bit makes a noisy sample
	// frames end in a one, so the line rests at mark between them
	task automatic send(input logic [11:0] frame, input int nBits,
		input int glitchBit);
		for (int i = 0; i < nBits; i++) begin
			for (int c = 0; c < BIT_CLKS; c++) begin
				@(posedge clk);
				serialOut <= frame[i] ^ (i == glitchBit && c >= 18 && c < 20);
			end
		end
	endtask
endmodule

/* File: test/asr_receiver_tb.sv */
`timescale 1ns/1ps
module asr_receiver_tb;
	import asr_pkg::*;
	localparam int BIT_CLKS = 32;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [31:0] NI = ~(32'h1 << S1_IDLE);
	typedef struct packed {
		logic err;
		logic [31:0] mask;
		logic [31:0] data;
	} asr_exp_s;
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic serialInPin;
	logic cpuWaitMode = 1'h0;
	logic rxIrq;
	logic errIrq;
	logic waitWake;
	int errCount = 0;
	int samplesChecked = 0;
	int seed = 32'h45a5b509;
	logic [7:0] byteA;
	logic [7:0] byteB;
	logic p;
	asr_exp_s expQ[$];
	always #25 clk = !clk;
	asr_receiver #(.BAUD_W(8)) DUT (.clk(clk), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serialInPin(serialInPin),
		.cpuWaitMode(cpuWaitMode), .rxIrq(rxIrq), .errIrq(errIrq),
		.waitWake(waitWake));
	asr_remote_tx #(.BIT_CLKS(BIT_CLKS)) remote (.clk(clk),
		.serialOut(serialInPin));
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", samplesChecked, errCount);
		if (errCount == 0 && samplesChecked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			errCount++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
			check({31'h0, pslverr}, {31'h0, expQ[0].err});
			check(prdata & expQ[0].mask, expQ[0].data & expQ[0].mask);
			void'(expQ.pop_front());
		end
	end
	// every wait is bounded so a dead bus cannot hang the run
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			errCount++;
			giveVerdict();
		end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic er = 1'h0);
		expQ.push_back('{er, m, e});
		apb(1'h0, a, 32'h0);
	endtask
	task automatic waitRx();
		int n;
		n = 0;
		while (rxIrq !== 1'h1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 2000) begin
			errCount++;
			giveVerdict();
		end
	endtask
	function automatic logic [31:0] b(input int i);
		return 32'h1 << i;
	endfunction
	function automatic logic [11:0] f8(input logic [7:0] d);
		return {3'h7, d, 1'h0};
	endfunction
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'h1;
		rd(ADDR_CTRL_ONE, 32'h0, ALL);
		rd(ADDR_BAUD, {24'h0, BAUD_RESET}, ALL);
		rd(12'hFFC, 32'h0, 32'h0, 1'h1);
		wr(ADDR_BAUD, 32'h1);
		wr(ADDR_CTRL_ONE, b(C1_ENABLE));
		wr(ADDR_CTRL_TWO, b(C2_RX_EN) | b(C2_RX_FULL_IE));
		wr(ADDR_CTRL_THREE, b(C3_NOISE_IE));
		byteA = $random(seed);
		byteB = $random(seed);
		remote.send(f8(byteA), 10, -1);
		waitRx();
		rd(ADDR_STATUS_ONE, b(S1_FULL), NI);
		rd(ADDR_CTRL_THREE, {31'h0, byteA[7]}, 32'h1);
		rd(ADDR_DATA, {24'h0, byteA}, ALL);
		rd(ADDR_STATUS_ONE, 32'h0, NI);
		check({31'h0, rxIrq}, 32'h0);
		remote.send(f8(byteA), 10, -1);
		remote.send(f8(byteB), 10, -1);
		check({31'h0, errIrq}, 32'h0);
		rd(ADDR_STATUS_ONE, b(S1_FULL) | b(S1_OVERRUN), NI);
		rd(ADDR_DATA, {24'h0, byteA}, ALL);
		rd(ADDR_STATUS_ONE, 32'h0, NI);
		remote.send(f8(byteB), 10, 3);
		waitRx();
		check({31'h0, errIrq}, 32'h1);
		rd(ADDR_STATUS_ONE, b(S1_FULL) | b(S1_NOISE), NI);
		rd(ADDR_DATA, {24'h0, byteB}, ALL);
		// a one-tick low pulse must fail the 3/5/7 vote
		remote.send(12'hFFF, 1, 0);
		repeat (3 * BIT_CLKS) @(posedge clk);
		rd(ADDR_STATUS_ONE, 32'h0, NI);
		remote.send(f8(byteA), 10, -1);
		waitRx();
		rd(ADDR_STATUS_ONE, b(S1_FULL), NI);
		rd(ADDR_DATA, {24'h0, byteA}, ALL);
		remote.send(12'h400, 11, -1);
		waitRx();
		rd(ADDR_STATUS_ONE, b(S1_FULL) | b(S1_FRAMING), NI);
		rd(ADDR_STATUS_TWO, b(S2_BREAK), b(S2_BREAK));
		rd(ADDR_CTRL_THREE, 32'h0, 32'h1);
		rd(ADDR_DATA, 32'h0, ALL);
		wr(ADDR_CTRL_THREE, b(C3_PARITY_IE));
		for (int i = 0; i < 4; i++) begin
			p = ^byteB ^ i[1] ^ i[0];
			wr(ADDR_CTRL_ONE, b(C1_ENABLE) | b(C1_NINE) | b(C1_PARITY_ON)
				| (i[1] ? b(C1_PARITY_ODD) : 32'h0));
			remote.send({2'h3, p, byteB, 1'h0}, 11, -1);
			waitRx();
			check({31'h0, errIrq}, {31'h0, i[0]});
			rd(ADDR_STATUS_ONE, b(S1_FULL) | (i[0] ? b(S1_PARITY) : 0),
				NI);
			rd(ADDR_CTRL_THREE, {31'h0, p}, 32'h1);
			rd(ADDR_DATA, {24'h0, byteB}, ALL);
		end
		wr(ADDR_CTRL_THREE, 32'h0);
		wr(ADDR_CTRL_ONE, b(C1_ENABLE) | b(C1_WAKE_ADDR));
		wr(ADDR_CTRL_TWO, b(C2_RX_EN) | b(C2_RX_FULL_IE) | b(C2_STANDBY));
		remote.send(f8(byteA & 8'h7F), 10, -1);
		check({31'h0, rxIrq}, 32'h0);
		rd(ADDR_STATUS_ONE, 32'h0, b(S1_FULL));
		remote.send(f8(byteA | 8'h80), 10, -1);
		waitRx();
		rd(ADDR_CTRL_TWO, 32'h0, b(C2_STANDBY));
		rd(ADDR_STATUS_ONE, b(S1_FULL), NI);
		rd(ADDR_DATA, {24'h0, byteA | 8'h80}, ALL);
		wr(ADDR_CTRL_ONE, b(C1_ENABLE));
		repeat (12 * BIT_CLKS) @(posedge clk);
		rd(ADDR_STATUS_ONE, b(S1_IDLE), b(S1_IDLE));
		rd(ADDR_DATA, 32'h0, 32'h0);
		rd(ADDR_STATUS_ONE, 32'h0, b(S1_IDLE));
		// standby is set mid character so a stale idle cannot wake it
		fork
			remote.send(f8(byteB), 10, -1);
			begin
				repeat (3 * BIT_CLKS) @(posedge clk);
				wr(ADDR_CTRL_TWO, b(C2_RX_EN) | b(C2_IDLE_IE) | b(C2_STANDBY));
			end
		join
		repeat (13 * BIT_CLKS) @(posedge clk);
		rd(ADDR_CTRL_TWO, 32'h0, b(C2_STANDBY));
		rd(ADDR_STATUS_ONE, 32'h0, b(S1_IDLE) | b(S1_FULL));
		check({31'h0, rxIrq}, 32'h0);
		wr(ADDR_CTRL_TWO, b(C2_RX_EN) | b(C2_RX_FULL_IE));
		cpuWaitMode <= 1'h1;
		remote.send(f8(byteB), 10, -1);
		waitRx();
		repeat (2) @(posedge clk);
		check({31'h0, waitWake}, 32'h1);
		cpuWaitMode <= 1'h0;
		rd(ADDR_STATUS_ONE, b(S1_FULL), NI);
		rd(ADDR_DATA, {24'h0, byteB}, ALL);
		wr(ADDR_CTRL_ONE, 32'h0);
		cpuWaitMode <= 1'h1;
		remote.send(f8(byteA), 10, -1);
		repeat (2) @(posedge clk);
		check({31'h0, waitWake}, 32'h0);
		cpuWaitMode <= 1'h0;
		repeat (4) @(posedge clk);
		giveVerdict();
	end
endmodule
